// ---- smr_cfg.svh ----
// constants for the operating-control word decoder
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SMR_FRAME_BITS     16            // spi clocks per legal frame
`define SMR_ADDR_HI        15            // register select, upper bit
`define SMR_ADDR_LO        14            // register select, lower bit
`define SMR_FB_SEL_BIT     13            // feedback select
`define SMR_RO_BIT         12            // readback only
`define SMR_WPC_HI         11            // watchdog period code
`define SMR_WPC_LO         6
`define SMR_OMC_HI         5             // operating mode code
`define SMR_OMC_LO         3
`define SMR_DBG_BIT        2             // supervision off
`define SMR_EN_BIT         1             // enable output
`define SMR_ADDR_MODE      2'h0          // operating-control register select
`define SMR_RRS_LATCH_CNT  5'h03         // bits received once feedback select known

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define SMR_OM_UNDEF       3'h0
`define SMR_OM_NORMAL      3'h1
`define SMR_OM_STANDBY     3'h2
`define SMR_OM_INIT_FLASH  3'h3
`define SMR_OM_SLEEP       3'h4
`define SMR_OM_INIT_NORMAL 3'h5
`define SMR_OM_LEAVE_FLASH 3'h6
`define SMR_OM_FLASH       3'h7
`define SMR_WPC_OFF        6'h36         // off in standby and sleep

// ----------------------------------------------------------------
// reset values and reset causes
// ----------------------------------------------------------------
`define SMR_WPC_RST        6'h09
`define SMR_OMC_RST        3'h1
`define SMR_CAUSE_POR      4'h0
`define SMR_CAUSE_ILLEGAL  4'h5
`define SMR_CAUSE_FLASH    4'hb

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SMR_CLK_PERIOD_NS  50            // system clock, 20 mhz
`define SMR_OSC_KHZ        512           // watchdog oscillator
`define SMR_T_WD_INIT_MS   256           // initial watchdog window
`define SMR_T_RST_PULSE_US 20            // forced reset pulse
`define SMR_RST_PULSE_CYC  ((`SMR_T_RST_PULSE_US * 1000 + `SMR_CLK_PERIOD_NS - 1) / `SMR_CLK_PERIOD_NS)
`define SMR_WD_INIT_CYC    (`SMR_T_WD_INIT_MS * 1000000 / `SMR_CLK_PERIOD_NS)

`endif

// ---- smr_pkg.sv ----
// types for the operating-control word decoder
package smr_pkg;
    // flash entry sequence tracker
    typedef enum logic [2:0] {
        SEQ_IDLE      = 3'h0,
        SEQ_N1        = 3'h1,
        SEQ_F1        = 3'h2,
        SEQ_N2        = 3'h3,
        SEQ_WAIT_INIT = 3'h4,
        SEQ_FLASH     = 3'h5
    } smr_seq_t;
endpackage : smr_pkg

// ---- smr_spi_rx.sv ----
// spi frame shifter with pin synchronisers and feedback shift-out
`timescale 1ns/1ps
`include "smr_cfg.svh"

module smr_spi_rx
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        scs_n_pin,     // chip select pin, low active
    input  wire logic        sck_pin,       // spi clock pin
    input  wire logic        sdi_pin,       // serial data in
    input  wire logic [11:0] status_word,   // status feedback data
    input  wire logic [11:0] diag_word,     // diagnosis feedback data
    output logic             sdo_out,       // serial data out
    output logic             sdo_oe_n,      // low while driving sdo
    output logic             frame_valid,   // one-cycle, 16-clock frame ended
    output logic [15:0]      frame_data     // data of the last frame, complete or not
);
    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic [2:0]  scs_s;                     // [0],[1] sync, [2] history
    logic [2:0]  sck_s;
    logic [1:0]  sdi_s;
    logic [15:0] rx_q;                      // receive shift register
    logic [4:0]  cnt_q;                     // falling edges seen
    logic [4:0]  rise_q;                    // rising edges seen
    logic        rrs_q;                     // latched feedback select
    logic        sdo_q;
    logic        act;
    logic        sck_fall;
    logic        sck_rise;
    logic        scs_fall;
    logic        scs_rise;
    logic [15:0] tx_word;

    // two stages before use
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scs_s <= 3'h7;
            sck_s <= 3'h0;
            sdi_s <= 2'h0;
        end
        else
        begin
            scs_s <= {scs_s[1:0], scs_n_pin};
            sck_s <= {sck_s[1:0], sck_pin};
            sdi_s <= {sdi_s[0], sdi_pin};
        end
    end

    assign act      = ~scs_s[1];
    assign sck_fall = sck_s[2] & ~sck_s[1] & act;
    assign sck_rise = ~sck_s[2] & sck_s[1] & act;
    assign scs_fall = scs_s[2] & ~scs_s[1];
    assign scs_rise = ~scs_s[2] & scs_s[1];

    // ----------------------------------------------------------------
    // receive, sample on falling sck
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_q        <= 16'h0000;
            cnt_q       <= 5'h00;
            frame_valid <= 1'b0;
            frame_data  <= 16'h0000;
        end
        else
        begin
            frame_valid <= 1'b0;
            if (scs_fall)
            begin
                rx_q  <= 16'h0000;
                cnt_q <= 5'h00;
            end
            else if (sck_fall)
            begin
                rx_q <= {rx_q[14:0], sdi_s[1]};
                // saturate so overlong frames stay wrong
                if (cnt_q != 5'h11)
                    cnt_q <= cnt_q + 5'h01;
            end
            // only exact 16-clock frames count
            if (scs_rise)
            begin
                frame_valid <= (cnt_q == 5'(`SMR_FRAME_BITS));
                frame_data  <= rx_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit, shift on rising sck
    // ----------------------------------------------------------------
    // header nibble answers zero, data follows the chosen feedback
    assign tx_word = {4'h0, rrs_q ? diag_word : status_word};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rise_q <= 5'h00;
            rrs_q  <= 1'b0;
            sdo_q  <= 1'b0;
        end
        else
        begin
            if (scs_fall)
            begin
                rise_q <= 5'h00;
                rrs_q  <= 1'b0;
                sdo_q  <= 1'b0;
            end
            else
            begin
                // feedback select is the third received bit
                if (cnt_q == `SMR_RRS_LATCH_CNT)
                    rrs_q <= rx_q[0];
                if (sck_rise && rise_q < 5'h10)
                begin
                    sdo_q  <= tx_word[4'hf - rise_q[3:0]];
                    rise_q <= rise_q + 5'h01;
                end
            end
        end
    end

    assign sdo_out  = sdo_q;
    assign sdo_oe_n = scs_s[1];

    // data bit 11 follows the chosen feedback
    property p_fb_sel;
        @(posedge clk) disable iff (rst)
        (sck_rise && rise_q == 5'h04 && !scs_fall)
            |=> (sdo_q == (rrs_q ? diag_word[11] : status_word[11]));
    endproperty
    a_fb_sel: assert property (p_fb_sel) else $error("feedback bit wrong");
endmodule : smr_spi_rx

// ---- smr_mode_ctrl.sv ----
// operating-control word decoder with flash entry sequence
//
// Function
// - top two bits 00 select this register
// - bit 13 picks diagnosis or status feedback
// - bit 12 set: feedback only, no write
// - bit 12 clear: feedback and register load
// - periods counted in 512 khz oscillator ticks
// - bit 2 turns supervision off
// - bit 1 drives the enable output
// - flash only via normal,flash,normal,flash writes
// - last sequence write forces a system reset
// - sequence reset leaves its own reset cause
// - init flash within window completes entry
// - illegal codes ignored and force reset
`timescale 1ns/1ps
`include "smr_cfg.svh"

module smr_mode_ctrl
#(
    parameter int INIT_WIN_CYC = `SMR_WD_INIT_CYC  // initial watchdog window
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        scs_n,               // spi chip select pin
    input  wire logic        sck,                 // spi clock pin
    input  wire logic        sdi,                 // spi data in pin
    output logic             sdo_out,             // spi data out
    output logic             sdo_oe_n,            // low while driving sdo
    input  wire logic [11:0] status_word,         // status feedback
    input  wire logic [11:0] diag_word,           // diagnosis feedback
    output logic             enable_out,          // enable output pin
    output logic             debug_supervision_off,
    output logic [5:0]       watchdog_period_code,
    output logic [2:0]       operating_mode_code,
    output logic             wd_serve,            // pulse per accepted write
    output logic [15:0]      wd_period_ticks,     // normal-mode period, osc ticks
    output logic             wd_off_low_power,    // watchdog off in standby/sleep
    output logic             flash_mode,          // flash mode reached
    output logic             system_reset_out_n,  // forced system reset, low
    output logic [3:0]       reset_cause          // cause of last forced reset
);
    // ----------------------------------------------------------------
    // frame capture and field decode
    // ----------------------------------------------------------------
    logic              fv;                       // frame valid pulse
    logic [15:0]       fd;                       // frame data
    logic [1:0]        addr;
    logic              ro;
    logic [5:0]        wpc;
    logic [2:0]        omc;
    logic              wr;                       // frame for this register
    logic              legal;                    // codes defined
    logic              bad;                      // illegal write
    logic              apply;                    // legal load
    logic              seq_done;                 // last flash entry write
    logic [5:0]        wpc_q;
    logic [2:0]        omc_q;
    logic              dbg_q;
    logic              en_q;
    logic              serve_q;
    logic [15:0]       ticks_q;
    logic [8:0]        rst_cnt_q;                // forced reset length
    logic              system_reset_out_n_q;
    logic [3:0]        cause_q;
    logic [22:0]       win_q;                    // initial window timer
    smr_pkg::smr_seq_t st_q;
    smr_pkg::smr_seq_t st_d;

    smr_spi_rx u_rx
    (
        .clk         (clk),
        .rst         (rst),
        .scs_n_pin   (scs_n),
        .sck_pin     (sck),
        .sdi_pin     (sdi),
        .status_word (status_word),
        .diag_word   (diag_word),
        .sdo_out     (sdo_out),
        .sdo_oe_n    (sdo_oe_n),
        .frame_valid (fv),
        .frame_data  (fd)
    );

    // nominal normal-mode period in ms, zero for undefined codes
    function automatic logic [7:0] wd_ms(input logic [5:0] c);
        case (c)
            6'h09:   wd_ms = 8'h04;
            6'h0c:   wd_ms = 8'h08;
            6'h12:   wd_ms = 8'h10;
            6'h14:   wd_ms = 8'h20;
            6'h1b:   wd_ms = 8'h28;
            6'h24:   wd_ms = 8'h30;
            6'h2d:   wd_ms = 8'h38;
            6'h33:   wd_ms = 8'h40;
            6'h35:   wd_ms = 8'h48;
            6'h36:   wd_ms = 8'h50;
            default: wd_ms = 8'h00;
        endcase
    endfunction : wd_ms

    assign addr  = fd[`SMR_ADDR_HI:`SMR_ADDR_LO];
    assign ro    = fd[`SMR_RO_BIT];
    assign wpc   = fd[`SMR_WPC_HI:`SMR_WPC_LO];
    assign omc   = fd[`SMR_OMC_HI:`SMR_OMC_LO];
    assign wr    = fv && (addr == `SMR_ADDR_MODE);
    assign legal = (wd_ms(wpc) != 8'h00) && (omc != `SMR_OM_UNDEF);
    assign bad   = wr && !legal;
    // writes while the forced reset is low are not taken
    assign apply = wr && legal && !ro && system_reset_out_n_q;
    assign seq_done = apply && (st_q == smr_pkg::SEQ_N2) && (omc == `SMR_OM_FLASH);

    // ----------------------------------------------------------------
    // control word fields
    // ----------------------------------------------------------------
    // load only on legal writes; bit 0 is not stored
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wpc_q <= `SMR_WPC_RST;
            omc_q <= `SMR_OMC_RST;
            dbg_q <= 1'b0;
            en_q  <= 1'b0;
        end
        else if (apply)
        begin
            wpc_q <= wpc;
            omc_q <= omc;
            dbg_q <= fd[`SMR_DBG_BIT];
            en_q  <= fd[`SMR_EN_BIT];
        end
    end

    // watchdog service pulse and period in oscillator ticks
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            serve_q <= 1'b0;
            ticks_q <= 16'h0000;
        end
        else
        begin
            serve_q <= apply;
            ticks_q <= 16'(wd_ms(wpc_q) * `SMR_OSC_KHZ);
        end
    end

    // ----------------------------------------------------------------
    // forced system reset and its cause
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rst_cnt_q <= 9'h000;
            system_reset_out_n_q    <= 1'b1;
            cause_q   <= `SMR_CAUSE_POR;
        end
        else if (bad || seq_done)
        begin
            rst_cnt_q <= 9'(`SMR_RST_PULSE_CYC);
            system_reset_out_n_q    <= 1'b0;
            cause_q   <= bad ? `SMR_CAUSE_ILLEGAL : `SMR_CAUSE_FLASH;
        end
        else if (rst_cnt_q != 9'h000)
        begin
            rst_cnt_q <= rst_cnt_q - 9'h001;
            if (rst_cnt_q == 9'h001)
                system_reset_out_n_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // flash entry sequence
    // ----------------------------------------------------------------
    // any other legal write breaks the chain
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            smr_pkg::SEQ_IDLE:
                if (apply && omc == `SMR_OM_NORMAL)
                    st_d = smr_pkg::SEQ_N1;
            smr_pkg::SEQ_N1:
                if (apply)
                    st_d = (omc == `SMR_OM_FLASH) ? smr_pkg::SEQ_F1 :
                           (omc == `SMR_OM_NORMAL) ? smr_pkg::SEQ_N1 : smr_pkg::SEQ_IDLE;
            smr_pkg::SEQ_F1:
                if (apply)
                    st_d = (omc == `SMR_OM_NORMAL) ? smr_pkg::SEQ_N2 : smr_pkg::SEQ_IDLE;
            smr_pkg::SEQ_N2:
                if (apply)
                    st_d = (omc == `SMR_OM_FLASH) ? smr_pkg::SEQ_WAIT_INIT :
                           (omc == `SMR_OM_NORMAL) ? smr_pkg::SEQ_N1 : smr_pkg::SEQ_IDLE;
            smr_pkg::SEQ_WAIT_INIT:
                // init flash inside the window finishes entry
                if (apply)
                    st_d = (omc == `SMR_OM_INIT_FLASH) ? smr_pkg::SEQ_FLASH
                                                        : smr_pkg::SEQ_IDLE;
                else if (system_reset_out_n_q && win_q == 23'(INIT_WIN_CYC - 1))
                    st_d = smr_pkg::SEQ_IDLE;
            smr_pkg::SEQ_FLASH:
                if (apply && omc == `SMR_OM_LEAVE_FLASH)
                    st_d = smr_pkg::SEQ_IDLE;
            default:
                st_d = smr_pkg::SEQ_IDLE;
        endcase
        // an illegal write restarts the chain
        if (bad)
            st_d = smr_pkg::SEQ_IDLE;
    end

    // state and window timer, timer runs once the reset is released
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q  <= smr_pkg::SEQ_IDLE;
            win_q <= 23'h000000;
        end
        else
        begin
            st_q <= st_d;
            if (st_q != smr_pkg::SEQ_WAIT_INIT)
                win_q <= 23'h000000;
            else if (system_reset_out_n_q)
                win_q <= win_q + 23'h000001;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign enable_out            = en_q;
    assign debug_supervision_off = dbg_q;
    assign watchdog_period_code  = wpc_q;
    assign operating_mode_code   = omc_q;
    assign wd_serve              = serve_q;
    assign wd_period_ticks       = ticks_q;
    assign wd_off_low_power      = (wpc_q == `SMR_WPC_OFF);
    assign flash_mode            = (st_q == smr_pkg::SEQ_FLASH);
    assign system_reset_out_n    = system_reset_out_n_q;
    assign reset_cause           = cause_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ro_keep;
        (wr && ro) |=> $stable(omc_q) && $stable(wpc_q) && $stable(en_q);
    endproperty
    a_ro_keep: assert property (p_ro_keep) else $error("readback changed word");

    property p_load;
        apply |=> (omc_q == $past(omc)) && (wpc_q == $past(wpc)) && dbg_q == $past(fd[2]);
    endproperty
    a_load: assert property (p_load) else $error("word not loaded");

    property p_en_pin;
        apply |=> enable_out == $past(fd[1]);
    endproperty
    a_en_pin: assert property (p_en_pin) else $error("enable pin wrong");

    property p_illegal;
        bad |=> !system_reset_out_n && $stable(omc_q) && $stable(wpc_q);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal code not handled");

    property p_seq_rst;
        seq_done |=> !system_reset_out_n [*8];
    endproperty
    a_seq_rst: assert property (p_seq_rst) else $error("no sequence reset");

    property p_cause;
        seq_done |=> reset_cause == `SMR_CAUSE_FLASH;
    endproperty
    a_cause: assert property (p_cause) else $error("reset cause wrong");

    property p_init_flash;
        (st_q == smr_pkg::SEQ_WAIT_INIT && apply && omc == `SMR_OM_INIT_FLASH) |=> flash_mode;
    endproperty
    a_init_flash: assert property (p_init_flash) else $error("flash not entered");

    property p_only_path;
        $rose(flash_mode) |-> $past(st_q) == smr_pkg::SEQ_WAIT_INIT;
    endproperty
    a_only_path: assert property (p_only_path) else $error("flash by other path");

    property p_wd_off;
        (apply && wpc == `SMR_WPC_OFF) |=> wd_off_low_power ##1 wd_period_ticks == 16'ha000;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog off code wrong");
endmodule : smr_mode_ctrl

// ---- smr_spi_master_model.sv ----
// spi master model standing in for the microcontroller
`timescale 1ns/1ps

module smr_spi_master_model
(
    output logic      sck,       // idle low outside frames
    output logic      scs_n,     // chip select, low active
    output logic      sdi,       // data towards the device
    input  wire logic sdo_out,   // data from the device
    input  wire logic sdo_oe_n   // low while the device drives sdo
);
    // ----------------------------------------------------------------
    // idle levels
    // ----------------------------------------------------------------
    initial
    begin
        sck   = 1'b0;
        scs_n = 1'b1;
        sdi   = 1'b0;
    end

    // one frame, msb first, nclk clock periods, data read before fall
    task automatic xfer(input logic [15:0] word, input int nclk, output logic [15:0] rx);
        rx    = 16'h0000;
        scs_n <= 1'b0;                      // called on a clock edge, so no race
        #213;
        for (int i = 0; i < nclk; i++)
        begin
            sdi = word[15 - (i % 16)];
            sck = 1'b1;
            #200;
            rx  = {rx[14:0], sdo_oe_n ? 1'bx : sdo_out};
            sck = 1'b0;
            #200;
        end
        scs_n = 1'b1;
        sdi   = ~sdi;                       // released line drops stale value
        #437;
    endtask : xfer
endmodule : smr_spi_master_model

// ---- testbench.sv ----
// self-checking bench for the operating-control word decoder
`timescale 1ns/1ps

module testbench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 1'b0, rst = 1'b1, sck, scs_n, sdi, sdo_out, sdo_oe_n;
    logic [11:0] status_word = 12'h000, diag_word = 12'h000;
    logic en, dbg, serve, off, flash, rout_n;
    logic [5:0] wpc;
    logic [2:0] omc;
    logic [15:0] ticks, rx, stored;
    logic [3:0] cause;
    int errors, n_tests, n_serve, low_cnt, seed, s0;
    logic [5:0] codes[10] = '{6'h09, 6'h0c, 6'h12, 6'h14, 6'h1b, 6'h24, 6'h2d, 6'h33, 6'h35, 6'h36};
    int ms[10] = '{4, 8, 16, 32, 40, 48, 56, 64, 72, 80};
    logic [2:0] modes[4] = '{3'h2, 3'h4, 3'h5, 3'h6};

    always #25 clk = ~clk;                 // 20 mhz

    smr_mode_ctrl #(.INIT_WIN_CYC(2000)) i_dut (.clk(clk), .rst(rst), .scs_n(scs_n),
        .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .status_word(status_word), .diag_word(diag_word), .enable_out(en),
        .debug_supervision_off(dbg), .watchdog_period_code(wpc), .operating_mode_code(omc),
        .wd_serve(serve), .wd_period_ticks(ticks), .wd_off_low_power(off),
        .flash_mode(flash), .system_reset_out_n(rout_n), .reset_cause(cause));

    smr_spi_master_model i_mst (.sck(sck), .scs_n(scs_n), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n));

    // serve pulses and forced reset length
    always @(posedge clk)
    begin
        if (serve === 1'b1) n_serve++;
        if (rout_n === 1'b0) low_cnt++;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int ms_of(input logic [5:0] c);
        for (int k = 0; k < 10; k++) if (codes[k] == c) return ms[k];
        return -1;
    endfunction : ms_of

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // one frame then settle; reserved bit 0 always sent as zero
    task automatic op(input logic [15:0] w, input int nclk);
        @(posedge clk);
        status_word <= 12'($urandom);
        diag_word   <= 12'($urandom);
        @(posedge clk);
        s0 = n_serve;
        i_mst.xfer({w[15:1], 1'b0}, nclk, rx);
        repeat (10) @(posedge clk);
    endtask : op

    task automatic chk_regs();
        check({en, dbg, wpc, omc}, {stored[1], stored[2], stored[11:6], stored[5:3]});
        check(ticks, 20'(ms_of(stored[11:6]) * 512));
        check(off, stored[11:6] == 6'h36);
    endtask : chk_regs

    task automatic wait_rel();
        for (int k = 0; k < 1000 && rout_n !== 1'b1; k++) @(posedge clk);
    endtask : wait_rel

    task automatic summarize();
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    function automatic logic [15:0] mk(input logic [2:0] m, input logic [5:0] c);
        return {4'h0, c, m, 3'($urandom) & 3'h6};
    endfunction : mk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [5:0] bad;
        seed = $urandom(32'h32b0);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        stored = 16'h0248;
        chk_regs();
        check({rout_n, cause, flash, serve}, 7'h40);
        // random legal writes with both feedback selections
        for (int t = 0; t < 20; t++)
        begin
            // write 1 always carries the code that turns the watchdog off
            stored = mk(t % 3 == 0 ? 3'h1 : modes[$urandom % 4],
                codes[t == 1 ? 9 : $urandom % 10]);
            stored[13] = t[0];
            op(stored, 16);
            check(rx, {4'h0, stored[13] ? diag_word : status_word});
            check(20'(n_serve - s0), 20'h00001);
            chk_regs();
            check(en, stored[1]);
        end
        // refused frames: read only, other address, wrong clock counts
        for (int t = 0; t < 8; t++)
        begin
            // bad clock counts go to this register so only the count refuses them
            op(mk(modes[t % 4], codes[t]) | (t < 2 ? 16'(t * 2 + 1) << 12 :
                (t < 6 ? 16'(t % 3 + 1) << 14 : 16'h0000)), t == 6 ? 15 : (t == 7 ? 17 : 16));
            if (t < 2) check(rx[11:0], t ? diag_word : status_word);
            check(20'(n_serve - s0), 20'h00000);
            chk_regs();
        end
        // undefined mode, then undefined period code
        for (int t = 0; t < 2; t++)
        begin
            do bad = 6'($urandom); while (ms_of(bad) >= 0);
            low_cnt = 0;
            op(t == 0 ? mk(3'h0, 6'h12) : mk(3'h1, bad), 16);
            wait_rel();
            check(20'(low_cnt), 20'h00190);
            check(cause, 4'h5);
            chk_regs();
        end
        // broken chain: normal, flash, normal, standby
        op(mk(3'h1, 6'h09), 16);
        op(mk(3'h7, 6'h09), 16);
        op(mk(3'h1, 6'h09), 16);
        op(mk(3'h2, 6'h09), 16);
        check({rout_n, cause, flash}, 6'h2a);
        // full chain: normal, flash, normal, flash
        for (int t = 0; t < 4; t++)
        begin
            low_cnt = 0;
            op(mk(t[0] ? 3'h7 : 3'h1, 6'h0c), 16);
        end
        wait_rel();
        check(20'(low_cnt), 20'h00190);
        check({cause, flash}, 5'h16);
        op(mk(3'h3, 6'h0c), 16);
        check(flash, 1'b1);
        // leave flash code drops flash mode again
        op(mk(3'h6, 6'h0c), 16);
        check(flash, 1'b0);
        summarize();
    end

    // hang guard
    initial
    begin
        #(50 * 40000);
        errors++;
        summarize();
    end
endmodule : testbench
